// *** design/modbus_register_query_responder.sv ***
`timescale 1ns/1ns
`include "query_regs.svh"

module modbus_register_query_responder #(
   parameter int FLASH_HALF_CYCLES = `FLASH_HALF_MS * `CLOCK_KHZ
) (
   input  wire logic        i_clock,
   input  wire logic        i_reset,
   input  wire logic        i_rx_valid,
   input  wire logic [7:0]  i_rx_data,
   input  wire logic        i_rx_last,
   output logic             o_rx_ready,
   output logic             o_tx_valid,
   output logic [7:0]       o_tx_data,
   output logic             o_tx_last,
   input  wire logic        i_tx_ready,
   output logic             o_gear_query,
   output logic [31:0]      o_gear_command,
   input  wire logic        i_gear_answer_valid,
   input  wire logic [7:0]  i_gear_answer,
   input  wire logic [3:0]  i_relay_closed,
   input  wire logic        i_event_valid,
   input  wire logic [31:0] i_event_record,
   input  wire logic        i_set_button,
   input  wire logic        i_usb_present,
   input  wire logic        i_fw_done,
   output logic             o_upgrade_mode,
   output logic             o_restart,
   output logic             o_lamp_a,
   output logic             o_lamp_b
);
   import query_pkg::*;

   responder_t q;
   responder_t d;

   // ----------------------------------------------------------------
   // Register contents seen by a read
   // ----------------------------------------------------------------
   function automatic logic [15:0] reg_value(input responder_t s,
                                             input logic [7:0] r);
      logic [31:0] rec;
      rec = s.log_mem[r[7:1]];
      reg_value = 16'h0000;
      unique case (s.reply)
         RK_RELAY: reg_value = {(s.relay[r[1:0]] ? `RELAY_CLOSED
                                : 8'h00), 8'h00};
         RK_EVENT: reg_value = r[0] ? rec[15:0] : rec[31:16];
         RK_GEAR: begin
            unique case (r[1:0])
               2'h0: reg_value = s.cmd[31:16];
               2'h1: reg_value = s.cmd[15:0];
               2'h2: reg_value = {s.answer, 8'h00};
               2'h3: reg_value = 16'h0000;
            endcase
         end
         RK_ERROR: reg_value = 16'h0000;
      endcase
   endfunction : reg_value

   // ----------------------------------------------------------------
   // Reply byte at a given position
   // ----------------------------------------------------------------
   function automatic logic [7:0] reply_byte(input responder_t s,
                                             input logic [8:0] i);
      logic [8:0]  j;
      logic [8:0]  mlen;
      logic [15:0] v;
      j    = i - `HDR_TOTAL;
      mlen = s.tlen - 9'(`MBAP_FIXED);
      v    = reg_value(s, s.base + j[8:1]);
      unique case (i)
         9'h000: reply_byte = s.tid[15:8];
         9'h001: reply_byte = s.tid[7:0];
         9'h002: reply_byte = 8'h00;
         9'h003: reply_byte = 8'h00;
         9'h004: reply_byte = 8'h00;
         9'h005: reply_byte = mlen[7:0];
         9'h006: reply_byte = s.rxb[`POS_UNIT];
         9'h007: reply_byte = (s.reply == RK_ERROR) ?
                              (s.fc | `FC_ERR_BIT) : s.fc;
         9'h008: reply_byte = (s.reply == RK_ERROR) ?
                              s.exc : {s.qty[6:0], 1'b0};
         default: reply_byte = j[0] ? v[7:0] : v[15:8];
      endcase
   endfunction : reply_byte

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   logic [4:0]  cnt;
   logic [15:0] mlen;
   logic [15:0] start;
   logic [15:0] qty;
   logic [15:0] wstart;
   logic [15:0] wqty;
   logic [7:0]  fcode;
   logic        frame_ok;
   logic        rd_relay;
   logic        rd_event;
   logic        gear_ok;

   always_comb begin
      d        = q;
      cnt      = '0;
      mlen     = '0;
      start    = '0;
      qty      = '0;
      wstart   = '0;
      wqty     = '0;
      fcode    = '0;
      frame_ok = 1'b0;
      rd_relay = 1'b0;
      rd_event = 1'b0;
      gear_ok  = 1'b0;
      d.query   = 1'b0;
      d.restart = 1'b0;
      d.btn_s = {q.btn_s[1:0], i_set_button};
      d.usb_s = {q.usb_s[1:0], i_usb_present};
      if (q.btn_s[1] == q.btn_s[2]) begin
         d.btn = q.btn_s[2];
      end
      if (q.usb_s[1] == q.usb_s[2]) begin
         d.usb = q.usb_s[2];
      end
      if (!q.strap_done) begin
         if (q.wait_cnt == `STRAP_WAIT) begin
            d.strap_done = 1'b1;
            d.upgrade    = q.btn & ~q.usb;
         end else begin
            d.wait_cnt = q.wait_cnt + 3'h1;
         end
      end
      if (q.upgrade && i_fw_done) begin
         d.upgrade = 1'b0;
         d.restart = 1'b1;
      end
      if (i_event_valid && i_event_record[31:24] <= `EVT_ADDR_MAX &&
          i_event_record[23:16] >= `EVT_INST_MIN &&
          i_event_record[23:16] <= `EVT_INST_MAX) begin
         d.log_mem[q.wptr] = i_event_record;
         d.wptr = (q.wptr == `LOG_LAST) ? 7'h00 : q.wptr + 7'h01;
      end
      unique case (q.phase)
         ST_RX: begin
            if (i_rx_valid && q.rx_ready) begin
               if (q.rcnt < `RX_DEPTH) begin
                  d.rxb[q.rcnt] = i_rx_data;
               end
               cnt = (q.rcnt == `CNT_MAX) ? q.rcnt : q.rcnt + 5'h01;
               d.rcnt = cnt;
               if (i_rx_last) begin
                  d.rcnt = '0;
                  mlen   = {d.rxb[`POS_LEN], d.rxb[`POS_LEN + 5'h01]};
                  start  = {d.rxb[`POS_START], d.rxb[`POS_START + 5'h01]};
                  qty    = {d.rxb[`POS_QTY], d.rxb[`POS_QTY + 5'h01]};
                  wstart = {d.rxb[`POS_WSTART],
                            d.rxb[`POS_WSTART + 5'h01]};
                  wqty   = {d.rxb[`POS_WQTY], d.rxb[`POS_WQTY + 5'h01]};
                  fcode  = d.rxb[`POS_FC];
                  frame_ok = (d.rxb[`POS_PID] == 8'h00) &&
                             (d.rxb[`POS_PID + 5'h01] == 8'h00) &&
                             (cnt <= `RX_DEPTH) &&
                             (mlen == {11'h000, cnt} - `MBAP_FIXED);
                  rd_relay = qty != 16'h0000 && start >= `REG_RELAY &&
                             {1'b0, start} + {1'b0, qty} <=
                             {1'b0, `REG_RELAY} + {1'b0, `RELAY_REGS};
                  rd_event = qty != 16'h0000 && qty <= `READ_QTY_MAX &&
                             start >= `REG_EVENT_LOG &&
                             {1'b0, start} + {1'b0, qty} <=
                             {1'b0, `REG_EVENT_LOG} +
                             {1'b0, `EVENT_REGS};
                  gear_ok  = start == `REG_GEAR_RESULT &&
                             qty == `GEAR_RESULT_REGS &&
                             wstart == `REG_GEAR_CMD &&
                             wqty == `GEAR_CMD_REGS &&
                             d.rxb[`POS_BC] == `GEAR_CMD_BYTES;
                  if (cnt >= `MIN_FRAME) begin
                     d.tid   = {d.rxb[`POS_TID], d.rxb[`POS_TID + 5'h01]};
                     d.fc    = fcode;
                     d.tidx  = '0;
                     d.phase = ST_TX;
                     d.reply = RK_ERROR;
                     d.exc   = `EXC_BAD_DATA;
                     d.tlen  = `ERR_TOTAL;
                     d.relay = i_relay_closed;
                     if (fcode == `FC_READ) begin
                        if (frame_ok && cnt == `FRAME_READ &&
                            (rd_relay || rd_event)) begin
                           d.reply = rd_relay ? RK_RELAY : RK_EVENT;
                           d.base  = rd_relay ? 8'(start - `REG_RELAY)
                                     : 8'(start - `REG_EVENT_LOG);
                           d.qty   = qty[7:0];
                           d.tlen  = `HDR_TOTAL + {qty[7:0], 1'b0};
                        end
                     end else if (fcode == `FC_READ_WRITE) begin
                        if (frame_ok && cnt == `FRAME_RW && gear_ok) begin
                           d.cmd   = {d.rxb[`POS_WDATA],
                                      d.rxb[`POS_WDATA + 5'h01],
                                      d.rxb[`POS_WDATA + 5'h02],
                                      d.rxb[`POS_WDATA + 5'h03]};
                           d.query = 1'b1;
                           d.phase = ST_GEAR;
                        end
                     end else begin
                        d.exc = `EXC_BAD_FUNC;
                     end
                  end
               end
            end
         end
         ST_GEAR: begin
            if (i_gear_answer_valid) begin
               d.answer = i_gear_answer;
               d.reply  = RK_GEAR;
               d.base   = 8'h00;
               d.qty    = 8'(`GEAR_RESULT_REGS);
               d.tlen   = `GEAR_TOTAL;
               d.phase  = ST_TX;
            end
         end
         ST_TX: begin
            if (!q.tx_valid || i_tx_ready) begin
               if (q.tidx == q.tlen) begin
                  d.tx_valid = 1'b0;
                  d.tx_last  = 1'b0;
                  d.phase    = ST_RX;
               end else begin
                  d.tx_valid = 1'b1;
                  d.tx_data  = reply_byte(q, q.tidx);
                  d.tx_last  = (q.tidx == q.tlen - 9'h001);
                  d.tidx     = q.tidx + 9'h001;
               end
            end
         end
      endcase
      d.rx_ready = (d.phase == ST_RX);
   end

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         q       <= '0;
         q.phase <= ST_RX;
         q.reply <= RK_ERROR;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // Upgrade lamps
   // ----------------------------------------------------------------
   lamp_flasher #(
      .HALF_CYCLES (FLASH_HALF_CYCLES)
   ) lamp_flasher_inst (
      .i_clock  (i_clock),
      .i_reset  (i_reset),
      .i_enable (q.upgrade),
      .o_lamp_a (o_lamp_a),
      .o_lamp_b (o_lamp_b)
   );

   assign o_rx_ready     = q.rx_ready;
   assign o_tx_valid     = q.tx_valid;
   assign o_tx_data      = q.tx_data;
   assign o_tx_last      = q.tx_last;
   assign o_gear_query   = q.query;
   assign o_gear_command = q.cmd;
   assign o_upgrade_mode = q.upgrade;
   assign o_restart      = q.restart;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_query_waits: assert property (@(posedge i_clock) disable iff (i_reset)
      q.query |-> q.phase == ST_GEAR && $past(i_rx_last))
      else $error("gear query not followed by wait");
   a_gear_count: assert property (@(posedge i_clock) disable iff (i_reset)
      q.tx_valid && q.reply == RK_GEAR && q.tidx == 9'h009
      |-> q.tx_data == 8'h08)
      else $error("gear reply byte count wrong");
   a_gear_echo: assert property (@(posedge i_clock) disable iff (i_reset)
      q.tx_valid && q.reply == RK_GEAR && q.tidx == 9'h00A
      |-> q.tx_data == q.cmd[31:24])
      else $error("gear reply does not echo command");
   a_relay_first: assert property (@(posedge i_clock) disable iff (i_reset)
      q.tx_valid && q.reply == RK_RELAY && q.base == 8'h00 &&
      q.tidx == 9'h00A |-> q.tx_data == (q.relay[0] ? 8'h01 : 8'h00))
      else $error("relay state byte wrong");
   a_err_fc_msb: assert property (@(posedge i_clock) disable iff (i_reset)
      q.tx_valid && q.reply == RK_ERROR && q.tidx == 9'h008
      |-> q.tx_data == {1'b1, q.fc[6:0]})
      else $error("error reply function byte wrong");
   a_err_len_three: assert property (@(posedge i_clock) disable iff (i_reset)
      q.tx_valid && q.reply == RK_ERROR && q.tidx == 9'h006
      |-> q.tx_data == 8'h03)
      else $error("error reply length not three");
   a_bad_func_code: assert property (@(posedge i_clock) disable iff (i_reset)
      q.tx_valid && q.reply == RK_ERROR && q.tidx == 9'h009 &&
      q.fc != 8'h03 && q.fc != 8'h17 |-> q.tx_data == 8'h01)
      else $error("unsupported function code not refused");
   a_err_keeps_cmd: assert property (@(posedge i_clock) disable iff (i_reset)
      $rose(q.phase == ST_TX) && q.reply == RK_ERROR
      |-> $stable(q.cmd))
      else $error("exception changed gear command");
   a_log_wraps: assert property (@(posedge i_clock) disable iff (i_reset)
      $past(q.wptr) == 7'h7F && q.wptr != 7'h7F |-> q.wptr == 7'h00)
      else $error("event log did not wrap");
   a_flash_alt: assert property (@(posedge i_clock) disable iff (i_reset)
      q.upgrade && $past(q.upgrade) |-> o_lamp_a != o_lamp_b)
      else $error("lamps not alternating in upgrade mode");
   a_restart_pulse: assert property (@(posedge i_clock) disable iff (i_reset)
      q.upgrade && i_fw_done |=> q.restart && !q.upgrade
      ##1 !q.restart && !o_lamp_a && !o_lamp_b)
      else $error("no restart after firmware transfer");

endmodule : modbus_register_query_responder

// *** design/query_regs.svh ***
`ifndef QUERY_REGS_SVH
`define QUERY_REGS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define REG_GEAR_RESULT   16'h7D01
`define REG_RELAY         16'h80E9
`define REG_EVENT_LOG     16'h84D2
`define REG_GEAR_CMD      16'hA411
`define GEAR_RESULT_REGS  16'h0004
`define GEAR_CMD_REGS     16'h0002
`define GEAR_CMD_BYTES    8'h04
`define RELAY_REGS        16'h0004
`define EVENT_REGS        16'h0100
`define READ_QTY_MAX      16'h007D
`define RELAY_CLOSED      8'h01

// ----------------------------------------------------------------
// Function and exception codes
// ----------------------------------------------------------------
`define FC_READ           8'h03
`define FC_READ_WRITE     8'h17
`define FC_ERR_BIT        8'h80
`define EXC_BAD_FUNC      8'h01
`define EXC_BAD_DATA      8'h03

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define POS_TID           5'h00
`define POS_PID           5'h02
`define POS_LEN           5'h04
`define POS_UNIT          5'h06
`define POS_FC            5'h07
`define POS_START         5'h08
`define POS_QTY           5'h0A
`define POS_WSTART        5'h0C
`define POS_WQTY          5'h0E
`define POS_BC            5'h10
`define POS_WDATA         5'h11
`define MBAP_FIXED        16'h0006
`define MIN_FRAME         5'h08
`define FRAME_READ        5'h0C
`define FRAME_RW          5'h15
`define RX_DEPTH          5'h18
`define CNT_MAX           5'h1F
`define ERR_TOTAL         9'h009
`define HDR_TOTAL         9'h009
`define GEAR_TOTAL        9'h011

// ----------------------------------------------------------------
// Event record limits
// ----------------------------------------------------------------
`define EVT_ADDR_MAX      8'h3F
`define EVT_INST_MIN      8'h01
`define EVT_INST_MAX      8'h20
`define LOG_LAST          7'h7F

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define STRAP_WAIT        3'h4
`define FLASH_HALF_MS     250
`define CLOCK_KHZ         20000

`endif

// *** design/query_pkg.sv ***
package query_pkg;

   typedef enum logic [2:0] {
      ST_RX   = 3'b001,
      ST_GEAR = 3'b010,
      ST_TX   = 3'b100
   } phase_t;

   typedef enum logic [3:0] {
      RK_RELAY = 4'b0001,
      RK_EVENT = 4'b0010,
      RK_GEAR  = 4'b0100,
      RK_ERROR = 4'b1000
   } reply_t;

   typedef struct packed {
      phase_t              phase;
      reply_t              reply;
      logic [23:0][7:0]    rxb;
      logic [4:0]          rcnt;
      logic [31:0]         cmd;
      logic [7:0]          answer;
      logic [127:0][31:0]  log_mem;
      logic [6:0]          wptr;
      logic [3:0]          relay;
      logic [7:0]          exc;
      logic [7:0]          fc;
      logic [15:0]         tid;
      logic [7:0]          base;
      logic [7:0]          qty;
      logic [8:0]          tidx;
      logic [8:0]          tlen;
      logic                tx_valid;
      logic [7:0]          tx_data;
      logic                tx_last;
      logic                rx_ready;
      logic                query;
      logic [2:0]          btn_s;
      logic [2:0]          usb_s;
      logic                btn;
      logic                usb;
      logic [2:0]          wait_cnt;
      logic                strap_done;
      logic                upgrade;
      logic                restart;
   } responder_t;

   typedef struct packed {
      logic [22:0]         div;
      logic                lamp_a;
      logic                lamp_b;
   } flasher_t;

endpackage : query_pkg

// *** design/lamp_flasher.sv ***
`timescale 1ns/1ns
module lamp_flasher #(
   parameter int HALF_CYCLES = 5000000
) (
   input  wire logic i_clock,
   input  wire logic i_reset,
   input  wire logic i_enable,
   output logic      o_lamp_a,
   output logic      o_lamp_b
);
   import query_pkg::*;

   flasher_t q;
   flasher_t d;

   // ----------------------------------------------------------------
   // Alternate flashing of both lamps
   // ----------------------------------------------------------------
   always_comb begin
      d = q;
      if (!i_enable) begin
         d = '0;
      end else if (!q.lamp_a && !q.lamp_b) begin
         d.lamp_a = 1'b1;
         d.div    = '0;
      end else if (q.div == 23'(HALF_CYCLES - 1)) begin
         d.div    = '0;
         d.lamp_a = ~q.lamp_a;
         d.lamp_b = ~q.lamp_b;
      end else begin
         d.div = q.div + 23'h000001;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_lamp_a = q.lamp_a;
   assign o_lamp_b = q.lamp_b;

endmodule : lamp_flasher

// *** sim/modbus_client_model.sv ***
`timescale 1ns/1ns
// ------------------------------------------------------------
// Modbus client: sends request bytes, collects reply bytes
// ------------------------------------------------------------
module modbus_client_model (
   input  wire logic       i_clock,
   input  wire logic       i_rx_ready,
   input  wire logic       i_tx_valid,
   input  wire logic [7:0] i_tx_data,
   input  wire logic       i_tx_last,
   output logic            o_rx_valid,
   output logic [7:0]      o_rx_data,
   output logic            o_rx_last,
   output logic            o_tx_ready
);
   logic [7:0] rbuf [0:31];
   int         rn = 0;
   logic       slow = 1'b0;
   logic       got_last = 1'b0;

   initial begin
      o_rx_valid = 1'b0;
      o_rx_data  = 8'hA5;
      o_rx_last  = 1'b0;
      o_tx_ready = 1'b1;
   end

   // Each byte holds until taken; data inverted once released
   task automatic send(input logic [191:0] v, input int n);
      logic ok;
      for (int i = 0; i < n; i++) begin
         o_rx_valid <= 1'b1;
         o_rx_data  <= v[8*(n-1-i) +: 8];
         o_rx_last  <= (i == n - 1);
         do begin
            @(negedge i_clock);
            ok = i_rx_ready;
            @(posedge i_clock);
         end while (!ok);
      end
      o_rx_valid <= 1'b0;
      o_rx_last  <= 1'b0;
      o_rx_data  <= ~v[7:0];
   endtask : send

   // Slow mode stalls every other cycle
   task automatic recv(input int limit);
      logic       v;
      logic       l;
      logic [7:0] d;
      rn = 0;
      got_last = 1'b0;
      for (int t = 0; t < limit; t++) begin
         @(negedge i_clock);
         v = i_tx_valid;
         d = i_tx_data;
         l = i_tx_last;
         @(posedge i_clock);
         if (v && o_tx_ready) begin
            rbuf[rn % 32] = d;
            rn++;
            got_last = l;
            if (l)
               break;
         end
         o_tx_ready <= slow ? ~o_tx_ready : 1'b1;
      end
   endtask : recv
endmodule : modbus_client_model

// *** sim/modbus_register_query_responder_bench.sv ***
`timescale 1ns/1ns
module modbus_register_query_responder_bench;
   logic        clock, rx_valid, rx_last, rx_ready, tx_valid;
   logic        tx_last, tx_ready, gear_query, upgrade, restart;
   logic        lamp_a, lamp_b;
   logic [7:0]  rx_data, tx_data;
   logic [31:0] gear_command;
   logic        reset = 1'b1, ans_valid = 1'b0, ev_valid = 1'b0;
   logic        button = 1'b0, usb = 1'b1, fw_done = 1'b0;
   logic [7:0]  answer = 8'h00;
   logic [3:0]  relay = 4'h0;
   logic [31:0] ev_rec = 32'h0;
   int          errors = 0, n_tests = 0;

   modbus_register_query_responder #(.FLASH_HALF_CYCLES(8))
      modbus_register_query_responder_inst (
      .i_clock(clock), .i_reset(reset), .i_rx_valid(rx_valid),
      .i_rx_data(rx_data), .i_rx_last(rx_last), .o_rx_ready(rx_ready),
      .o_tx_valid(tx_valid), .o_tx_data(tx_data), .o_tx_last(tx_last),
      .i_tx_ready(tx_ready), .o_gear_query(gear_query),
      .o_gear_command(gear_command), .i_gear_answer_valid(ans_valid),
      .i_gear_answer(answer), .i_relay_closed(relay),
      .i_event_valid(ev_valid), .i_event_record(ev_rec),
      .i_set_button(button), .i_usb_present(usb), .i_fw_done(fw_done),
      .o_upgrade_mode(upgrade), .o_restart(restart),
      .o_lamp_a(lamp_a), .o_lamp_b(lamp_b));

   modbus_client_model client (
      .i_clock(clock), .i_rx_ready(rx_ready), .i_tx_valid(tx_valid),
      .i_tx_data(tx_data), .i_tx_last(tx_last), .o_rx_valid(rx_valid),
      .o_rx_data(rx_data), .o_rx_last(rx_last), .o_tx_ready(tx_ready));

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic get(input logic [191:0] e, input int ne);
      client.recv(400);
      check("reply length", client.rn, ne);
      check("reply last flag", client.got_last, 1'b1);
      for (int i = 0; i < ne; i++)
         check("reply byte", client.rbuf[i], e[8*(ne-1-i) +: 8]);
   endtask : get

   task automatic do_reset;
      reset <= 1'b1;
      repeat (16) @(posedge clock);
      reset <= 1'b0;
      repeat (2) @(posedge clock);
   endtask : do_reset

   task automatic push(input logic [31:0] r);
      ev_rec   <= r;
      ev_valid <= 1'b1;
      @(posedge clock);
   endtask : push

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic test_relay;
      relay <= 4'h5;
      client.send(96'h000100000006FF0380E90004, 12);
      @(negedge clock);
      check("ready during reply", rx_ready, 1'b0);
      get(136'h00010000000BFF03080100000001000000, 17);
      @(negedge clock);
      check("ready after reply", rx_ready, 1'b1);
      @(posedge clock);
   endtask : test_relay

   task automatic test_events;
      push(32'h01020303);
      push(32'h40010101);
      push(32'h01210101);
      ev_valid <= 1'b0;
      @(posedge clock);
      client.send(96'h000200000006FF0384D20002, 12);
      get(104'h000200000007FF030401020303, 13);
      for (int k = 0; k < 128; k++)
         push({2'b00, 6'(k), 8'h01, 8'h04, 8'(k)});
      ev_valid <= 1'b0;
      @(posedge clock);
      client.send(96'h000500000006FF0384D20004, 12);
      get(136'h00050000000BFF03083F01047F00010400, 17);
   endtask : test_events

   task automatic test_gear;
      client.slow = 1'b1;
      client.send({96'h00010000000FFF177D010004,
                   72'hA41100020401010001}, 21);
      for (int t = 0; t < 40 && gear_query !== 1'b1; t++)
         @(negedge clock);
      check("gear query", gear_query, 1'b1);
      check("gear command", gear_command, 32'h01010001);
      @(posedge clock);
      answer    <= 8'hE5;
      ans_valid <= 1'b1;
      @(posedge clock);
      ans_valid <= 1'b0;
      get(136'h00010000000BFF170801010001E5000000, 17);
      client.slow = 1'b0;
   endtask : test_gear

   task automatic test_errors;
      client.send(96'h000200000008FF0384D20002, 12);
      get(72'h000200000003FF8303, 9);
      client.send(96'h000300000006FF10A4110002, 12);
      get(72'h000300000003FF9001, 9);
      client.send({96'h00040001000FFF177D010004,
                   72'hA41100020402020202}, 21);
      get(72'h000400000003FF9703, 9);
      check("gear command", gear_command, 32'h01010001);
   endtask : test_errors

   task automatic test_upgrade;
      logic pa;
      button <= 1'b1;
      usb    <= 1'b0;
      do_reset;
      repeat (12) @(negedge clock);
      check("upgrade mode", upgrade, 1'b1);
      check("lamps alternate", lamp_a ^ lamp_b, 1'b1);
      pa = lamp_a;
      repeat (8) @(negedge clock);
      check("lamp toggle", lamp_a, !pa);
      @(posedge clock);
      fw_done <= 1'b1;
      @(posedge clock);
      fw_done <= 1'b0;
      @(negedge clock);
      check("restart", {restart, upgrade}, 2'b10);
      @(negedge clock);
      check("lamps off", {restart, lamp_a, lamp_b}, 3'b000);
   endtask : test_upgrade

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_of_test

   initial begin
      do_reset;
      test_relay;
      $display("relay test done");
      test_events;
      $display("event test done");
      test_gear;
      $display("gear test done");
      test_errors;
      $display("error test done");
      test_upgrade;
      $display("upgrade test done");
      end_of_test;
   end

   initial begin
      repeat (20000) @(posedge clock);
      errors++;
      end_of_test;
   end
endmodule : modbus_register_query_responder_bench
